// ### logic/error_capture.sv
/*
  Sticky error status word with its summary flag.
  Assumes error events and the read-clear pulse come from logic on the
  same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module error_capture
  import host_map_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic reset, // synchronous, active high
  input wire logic [15:0] events, // failure pulses from supervisors
  input wire logic [15:0] mask, // one masks the source
  input wire logic clear, // read of the status word
  output logic [15:0] status, // sticky failure bits
  output logic summary // unmasked failure since last read
);
  logic [15:0] seen;

  assign seen = events & host_map_pkg::ERROR_BITS;

  // a failure in the clearing cycle survives the clear
  always_ff @(posedge clock)
  begin
    if (reset)
      status <= host_map_pkg::RST_WORD;
    else if (clear)
      status <= seen;
    else
      status <= status | seen;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      summary <= 1'b0;
    else if (|(seen & ~mask))
      summary <= 1'b1;
    else if (clear)
      summary <= 1'b0;
  end

endmodule
`default_nettype wire

// ### logic/host_map_pkg.sv
/*
  Constants for the 16-bit host register map: offsets, field positions,
  reset values, writable masks and main interrupt status bit positions.
  Assumes nothing of its surroundings; imported by every design file.
*/
`default_nettype none
package host_map_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // byte offsets of the word and byte registers
  localparam logic [4:0] OFF_SOURCE_ADDRESS = 5'h00;
  localparam logic [4:0] OFF_DESTINATION_ADDRESS = 5'h02;
  localparam logic [4:0] OFF_GENERAL_PARAMETER = 5'h04;
  localparam logic [4:0] OFF_CONNECTION_COMMAND = 5'h06;
  localparam logic [4:0] OFF_CONFIG_COMMAND_FIRST = 5'h08;
  localparam logic [4:0] OFF_CONFIG_COMMAND_SECOND = 5'h0a;
  localparam logic [4:0] OFF_MESSAGE_VALUE = 5'h0c;
  localparam logic [4:0] OFF_MAIN_IRQ_STATUS = 5'h0e;
  localparam logic [4:0] OFF_ERROR_IRQ_STATUS = 5'h10;
  localparam logic [4:0] OFF_MAIN_IRQ_MASK = 5'h12;
  localparam logic [4:0] OFF_ERROR_IRQ_MASK = 5'h14;
  localparam logic [4:0] OFF_DEVICE_IDENTITY = 5'h1c;
  localparam logic [4:0] OFF_SLOT_VALUE_READBACK = 5'h1e;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_MAIN_IRQ_MASK = 8'h3d;
  localparam logic [15:0] RST_ERROR_IRQ_MASK = 16'hff3f;

  // bits that hold data; the rest are fixed zeros
  localparam logic [15:0] ADDRESS_WORD_BITS = 16'hff9f;
  localparam logic [15:0] CONN_COMMAND_BITS = 16'h3fff;
  localparam logic [15:0] ERROR_BITS = 16'hff3f;

  // address word fields
  localparam int TIME_SLOT_LSB = 8;
  localparam int BUS_TYPE_BIT = 7;
  localparam int PORT_LSB = 0;
  // connection command word fields
  localparam int OUTPUT_SUBCHANNEL_LSB = 11;
  localparam int INPUT_SUBCHANNEL_LSB = 8;
  localparam int QUALIFIER_LSB = 4;
  localparam int COMMAND_CODE_LSB = 0;

  // main interrupt status bit positions
  localparam int ST_ERROR_ONE = 0;
  localparam int ST_ERROR_TWO = 1;
  localparam int ST_READY = 2;
  localparam int ST_NO_FREE_CONN = 3;
  localparam int ST_SLOT_ARRIVED = 4;
  localparam int ST_GPIO = 5;
  localparam int ST_STREAM = 6;
  localparam int ST_PLL_LOCKED = 7;
  // only these bits may raise the interrupt request
  localparam logic [7:0] IRQ_CAPABLE = 8'h37;

endpackage
`default_nettype wire

// ### logic/host_register_map_16bit.sv
/*
  Register map of the switching device as seen by a 16-bit host bus:
  parameter, command, status, mask, identity and readback words.
  Assumes the host bus strobes are driven by logic on the same clock and
  that the internal connection controller reports back on this clock.
*/
// Function
// - source address word is slot 15:8, bus type 7, zeros 6:5, port 4:0, reset zero.
// - destination address word uses the same layout for the output side.
// - general parameter word holds the second byte high and first byte low, both read-write.
// - connection command word is zeros 15:14, subchannels, qualifier and code.
// - error status word reports the failures in bits 15:8 and 5:0, reset zero.
// - error mask word mirrors the status layout, one masks, reset ff3f.
// - the byte registers stay eight bits wide, each at its own even offset.
// - identity byte is fixed and ignores writes.
// - readback word gives memory contents high and slot value low.
// - connection commands are taken only while the ready flag is set.
// - some main status flags are status only and never raise the request.
// - ready clears on a connection command write and sets when it is done.
// - reading the error status word clears it and its summary flag.
// - configuration command writes are taken whatever the ready flag says.
`timescale 1ns/1ps
`default_nettype none
module host_register_map_16bit
  import host_map_pkg::*;
#(
  parameter logic [7:0] IDENTITY_VALUE = 8'h5a // arbitrary value
)
(
  input wire logic clock, // system clock, 100 MHz
  input wire logic reset, // synchronous, active high
  input wire logic host_select, // bus access qualifier
  input wire logic host_write, // write strobe
  input wire logic host_read, // read strobe
  input wire logic [host_map_pkg::ADDR_W-1:0] host_address, // byte addr
  input wire logic [15:0] host_write_data, // write data
  output logic [15:0] host_read_data, // read data
  output logic host_read_valid, // read data valid pulse
  output logic irq_request, // interrupt request, level
  output logic [15:0] source_address, // source slot, bus type, port
  output logic [15:0] destination_address, // destination fields
  output logic [15:0] general_parameter_word, // general value
  output logic [15:0] connection_command_word, // held command
  output logic connection_launch, // command taken pulse
  output logic [7:0] config_command_first, // first config command
  output logic [7:0] config_command_second, // second config command
  output logic config_launch_first, // first command written pulse
  output logic config_launch_second, // second command written pulse
  output logic [7:0] message_value, // message byte
  output logic ready_flag, // connection command register free
  input wire logic connection_established, // controller done pulse
  input wire logic no_free_connection, // controller status level
  input wire logic stream_connected, // stream controller status
  input wire logic pll_locked, // analog pll status
  input wire logic [15:0] error_events, // failure pulses
  input wire logic slot_value_update, // new readback value pulse
  input wire logic [15:0] slot_value_in, // readback value
  input wire logic gpio_change // general purpose change summary
);
  import host_map_pkg::*;

  logic write_hit;
  logic read_hit;
  logic [7:0] main_irq_mask;
  logic [15:0] error_irq_mask;
  logic [15:0] error_irq_status;
  logic error_summary;
  logic [15:0] slot_value_and_config_readback;
  logic slot_arrived;
  logic ready_event;
  logic [7:0] main_irq_status;
  logic [7:0] pending;
  logic [15:0] next_read_data;
  logic next_irq;

  function automatic logic hit(input logic [4:0] addr,
                               input logic [4:0] offset);
    hit = (addr == offset);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] data,
                                        input logic [15:0] keep);
    merge = data & keep;
  endfunction

  assign write_hit = host_select & host_write;
  assign read_hit = host_select & host_read;

  error_capture error_unit
  (
    .clock(clock),
    .reset(reset),
    .events(error_events),
    .mask(error_irq_mask),
    .clear(read_hit & hit(host_address, OFF_ERROR_IRQ_STATUS)),
    .status(error_irq_status),
    .summary(error_summary)
  );

  // parameter words
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      source_address <= RST_WORD;
      destination_address <= RST_WORD;
      general_parameter_word <= RST_WORD;
      message_value <= RST_BYTE;
    end
    else if (write_hit)
    begin
      if (hit(host_address, OFF_SOURCE_ADDRESS))
        source_address <= merge(host_write_data,
                                ADDRESS_WORD_BITS);
      if (hit(host_address, OFF_DESTINATION_ADDRESS))
        destination_address <= merge(host_write_data,
                                     ADDRESS_WORD_BITS);
      if (hit(host_address, OFF_GENERAL_PARAMETER))
        general_parameter_word <= host_write_data;
      if (hit(host_address, OFF_MESSAGE_VALUE))
        message_value <= host_write_data[7:0];
    end
  end

  // connection command and ready handshake
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      connection_command_word <= RST_WORD;
      connection_launch <= 1'b0;
    end
    else
    begin
      connection_launch <= 1'b0;
      if (write_hit && hit(host_address, OFF_CONNECTION_COMMAND)
          && ready_flag)
      begin
        connection_command_word <= merge(host_write_data,
                                         CONN_COMMAND_BITS);
        connection_launch <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      ready_flag <= 1'b0;
    else if (connection_established)
      ready_flag <= 1'b1;
    else if (connection_launch)
      ready_flag <= 1'b0;
    else if (write_hit && hit(host_address, OFF_CONNECTION_COMMAND))
      ready_flag <= 1'b0;
  end

  // ready rising edge is the interrupting event; main status read clears
  always_ff @(posedge clock)
  begin
    if (reset)
      ready_event <= 1'b0;
    else if (connection_established && !ready_flag)
      ready_event <= 1'b1;
    else if (read_hit && hit(host_address, OFF_MAIN_IRQ_STATUS))
      ready_event <= 1'b0;
  end

  // configuration commands ignore the ready flag
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      config_command_first <= RST_BYTE;
      config_command_second <= RST_BYTE;
      config_launch_first <= 1'b0;
      config_launch_second <= 1'b0;
    end
    else
    begin
      config_launch_first <= 1'b0;
      config_launch_second <= 1'b0;
      if (write_hit && hit(host_address, OFF_CONFIG_COMMAND_FIRST))
      begin
        config_command_first <= host_write_data[7:0];
        config_launch_first <= 1'b1;
      end
      if (write_hit && hit(host_address, OFF_CONFIG_COMMAND_SECOND))
      begin
        config_command_second <= host_write_data[7:0];
        config_launch_second <= 1'b1;
      end
    end
  end

  // mask registers
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      main_irq_mask <= RST_MAIN_IRQ_MASK;
      error_irq_mask <= RST_ERROR_IRQ_MASK;
    end
    else if (write_hit)
    begin
      if (hit(host_address, OFF_MAIN_IRQ_MASK))
        main_irq_mask <= host_write_data[7:0];
      if (hit(host_address, OFF_ERROR_IRQ_MASK))
        error_irq_mask <= merge(host_write_data, ERROR_BITS) |
                          ~ERROR_BITS;
    end
  end

  // readback word and its arrival flag; an update beats the read clear
  always_ff @(posedge clock)
  begin
    if (reset)
      slot_value_and_config_readback <= RST_WORD;
    else if (slot_value_update)
      slot_value_and_config_readback <= slot_value_in;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      slot_arrived <= 1'b0;
    else if (slot_value_update)
      slot_arrived <= 1'b1;
    else if (read_hit && hit(host_address, OFF_SLOT_VALUE_READBACK))
      slot_arrived <= 1'b0;
  end

  always_comb
  begin
    main_irq_status = 8'h00;
    main_irq_status[ST_ERROR_ONE] = error_summary;
    main_irq_status[ST_ERROR_TWO] = 1'b0;
    main_irq_status[ST_READY] = ready_flag;
    main_irq_status[ST_NO_FREE_CONN] = no_free_connection;
    main_irq_status[ST_SLOT_ARRIVED] = slot_arrived;
    main_irq_status[ST_GPIO] = gpio_change;
    main_irq_status[ST_STREAM] = stream_connected;
    main_irq_status[ST_PLL_LOCKED] = pll_locked;
    pending = main_irq_status;
    pending[ST_READY] = ready_event;
  end

  // status-only flags never reach the request; mask writes drop it
  always_comb
  begin
    next_irq = |(pending & ~main_irq_mask & IRQ_CAPABLE);
    if (write_hit && hit(host_address, OFF_MAIN_IRQ_MASK))
      next_irq = 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      irq_request <= 1'b0;
    else
      irq_request <= next_irq;
  end

  // read multiplexer; unmapped and odd addresses read zero
  always_comb
  begin
    next_read_data = 16'h0000;
    case (host_address)
      OFF_SOURCE_ADDRESS: next_read_data = source_address;
      OFF_DESTINATION_ADDRESS: next_read_data = destination_address;
      OFF_GENERAL_PARAMETER: next_read_data = general_parameter_word;
      OFF_CONNECTION_COMMAND: next_read_data = connection_command_word;
      OFF_CONFIG_COMMAND_FIRST:
        next_read_data = {8'h00, config_command_first};
      OFF_CONFIG_COMMAND_SECOND:
        next_read_data = {8'h00, config_command_second};
      OFF_MESSAGE_VALUE: next_read_data = {8'h00, message_value};
      OFF_MAIN_IRQ_STATUS: next_read_data = {8'h00, main_irq_status};
      OFF_ERROR_IRQ_STATUS: next_read_data = error_irq_status;
      OFF_MAIN_IRQ_MASK: next_read_data = {8'h00, main_irq_mask};
      OFF_ERROR_IRQ_MASK:
        next_read_data = merge(error_irq_mask, ERROR_BITS);
      OFF_DEVICE_IDENTITY: next_read_data = {8'h00, IDENTITY_VALUE};
      OFF_SLOT_VALUE_READBACK:
        next_read_data = slot_value_and_config_readback;
      default: next_read_data = 16'h0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      host_read_data <= 16'h0000;
      host_read_valid <= 1'b0;
    end
    else
    begin
      host_read_valid <= read_hit;
      if (read_hit)
        host_read_data <= next_read_data;
    end
  end

endmodule
`default_nettype wire

// ### verification/host_cpu_model.sv
/*
  Host processor model driving the register bus.
  Assumes the bench calls its tasks; drives at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
  import host_map_pkg::*;
(
  input wire logic clock, // system clock
  output logic host_select, // access qualifier
  output logic host_write, // write strobe
  output logic host_read, // read strobe
  output logic [host_map_pkg::ADDR_W-1:0] host_address, // byte address
  output logic [15:0] host_write_data, // write data
  input wire logic [15:0] host_read_data, // read data
  input wire logic host_read_valid // read data valid
);
  initial
  begin
    host_select = 1'b0;
    host_write = 1'b0;
    host_read = 1'b0;
    host_address = 5'h00;
    host_write_data = 16'h0000;
  end
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    host_select = 1'b1;
    host_write = 1'b1;
    host_address = a;
    host_write_data = d;
    @(negedge clock);
    host_select = 1'b0;
    host_write = 1'b0;
    // released data must not look valid
    host_write_data = ~d;
    if (a == OFF_CONFIG_COMMAND_FIRST || a == OFF_CONFIG_COMMAND_SECOND)
      repeat (12) @(negedge clock);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clock);
    host_select = 1'b1;
    host_read = 1'b1;
    host_address = a;
    @(negedge clock);
    host_select = 1'b0;
    host_read = 1'b0;
    d = host_read_valid ? host_read_data : 16'hxxxx;
  endtask
  // polls the status for ready up to 50 times, then writes the parameters and the command
  task automatic conn_cmd(input logic [15:0] s, dst, c);
    logic [15:0] st;
    st = 16'h0000;
    for (int i = 0; i < 50 && st[ST_READY] !== 1'b1; i++)
      rd(OFF_MAIN_IRQ_STATUS, st);
    wr(OFF_SOURCE_ADDRESS, s);
    wr(OFF_DESTINATION_ADDRESS, dst);
    wr(OFF_CONNECTION_COMMAND, c);
  endtask
endmodule
`default_nettype wire

// ### verification/host_register_map_16bit_properties.sv
/*
  Concurrent checks on the ports of the host register map.
  Assumes one clock domain with a synchronous active high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module host_map_checker
  import host_map_pkg::*;
#(
  parameter logic [7:0] IDENTITY_VALUE = 8'h5a // arbitrary value
)
(
  input wire logic clock, // system clock
  input wire logic reset, // synchronous reset
  input wire logic host_select, // access qualifier
  input wire logic host_write, // write strobe
  input wire logic host_read, // read strobe
  input wire logic [host_map_pkg::ADDR_W-1:0] host_address, // byte address
  input wire logic [15:0] host_write_data, // write data
  input wire logic [15:0] host_read_data, // read data
  input wire logic host_read_valid, // read data valid
  input wire logic [15:0] source_address, // source word
  input wire logic [15:0] destination_address, // destination word
  input wire logic [15:0] connection_command_word, // held command
  input wire logic connection_launch, // command taken
  input wire logic [7:0] config_command_first, // first config byte
  input wire logic config_launch_first, // first config taken
  input wire logic config_launch_second, // second config taken
  input wire logic ready_flag, // command register free
  input wire logic connection_established // controller done
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic conn_wr;
  logic src_wr;
  logic cf_wr;
  logic cs_wr;
  logic id_rd;
  logic [7:0] wd_low;
  assign conn_wr = host_select && host_write
    && host_address == OFF_CONNECTION_COMMAND;
  assign src_wr = host_select && host_write
    && host_address == OFF_SOURCE_ADDRESS;
  assign cf_wr = host_select && host_write
    && host_address == OFF_CONFIG_COMMAND_FIRST;
  assign cs_wr = host_select && host_write
    && host_address == OFF_CONFIG_COMMAND_SECOND;
  assign id_rd = host_select && host_read
    && host_address == OFF_DEVICE_IDENTITY;
  assign wd_low = host_write_data[7:0];
  property p_launch_gated;
    conn_wr |=> connection_launch == $past(ready_flag);
  endproperty
  a_launch_gated: assert property (p_launch_gated)
    else $error("command launch does not follow ready flag");
  property p_launch_value;
    connection_launch |-> $past(conn_wr) && connection_command_word
      == ($past(host_write_data) & CONN_COMMAND_BITS);
  endproperty
  a_launch_value: assert property (p_launch_value)
    else $error("launched command word wrong");
  property p_ready_clear;
    connection_launch && !connection_established |=> !ready_flag;
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("ready flag not cleared by launch");
  property p_ready_set;
    connection_established |=> ready_flag;
  endproperty
  a_ready_set: assert property (p_ready_set)
    else $error("ready flag not set after connection");
  property p_source_write;
    src_wr |=> source_address
      == ($past(host_write_data) & ADDRESS_WORD_BITS);
  endproperty
  a_source_write: assert property (p_source_write)
    else $error("source word write wrong");
  property p_fixed_zero;
    source_address[6:5] == 2'h0 && destination_address[6:5] == 2'h0
      && connection_command_word[15:14] == 2'h0;
  endproperty
  a_fixed_zero: assert property (p_fixed_zero)
    else $error("fixed zero field set");
  property p_config_first;
    cf_wr |=> config_launch_first && config_command_first == $past(wd_low);
  endproperty
  a_config_first: assert property (p_config_first)
    else $error("first config command not taken");
  property p_config_second;
    cs_wr ##1 !cs_wr |-> config_launch_second ##1 !config_launch_second;
  endproperty
  a_config_second: assert property (p_config_second)
    else $error("second config command pulse wrong");
  property p_identity;
    id_rd |=> host_read_valid
      && host_read_data == {8'h00, IDENTITY_VALUE};
  endproperty
  a_identity: assert property (p_identity)
    else $error("identity read wrong");
  c_launch: cover property (connection_launch);
  c_refused: cover property (conn_wr && !ready_flag);
  c_identity: cover property (id_rd);
endmodule
bind host_register_map_16bit host_map_checker
  #(.IDENTITY_VALUE(IDENTITY_VALUE)) u_checker (.clock, .reset,
  .host_select, .host_write, .host_read, .host_address, .host_write_data,
  .host_read_data, .host_read_valid, .source_address, .destination_address,
  .connection_command_word, .connection_launch, .config_command_first,
  .config_launch_first, .config_launch_second, .ready_flag,
  .connection_established);
`default_nettype wire

// ### verification/tb_host_register_map_16bit.sv
/*
  Self-checking bench for the host register map.
  Assumes the host model and the checker bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_host_register_map_16bit;
  import host_map_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  logic clock, reset, host_select, host_write, host_read, host_read_valid;
  logic [4:0] host_address;
  logic [15:0] host_write_data, host_read_data, source_address, slot_value_in;
  logic [15:0] destination_address, general_parameter_word, error_events;
  logic [15:0] connection_command_word;
  logic [7:0] config_command_first, config_command_second, message_value;
  logic irq_request, connection_launch, config_launch_first, ready_flag;
  logic config_launch_second, connection_established, no_free_connection;
  logic stream_connected, pll_locked, slot_value_update, gpio_change;
  int bad_count, comparisons, launches, cycles;
  logic [4:0] radr [15] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c,
    5'h0e, 5'h10, 5'h12, 5'h14, 5'h1c, 5'h1e, 5'h16, 5'h01};
  logic [15:0] rexp [15] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h003d, 16'hff3f,
    {8'h00, ID}, 16'h0000, 16'h0000, 16'h0000};
  logic [4:0] wadr [12] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h0a, 5'h0c, 5'h12,
    5'h14, 5'h1c, 5'h10, 5'h1e, 5'h16};
  logic [15:0] wexp [12] = '{16'hff9f, 16'hff9f, 16'hffff, 16'h00ff,
    16'h00ff, 16'h00ff, 16'h00ff, 16'hff3f, {8'h00, ID}, 16'h0000,
    16'h0000, 16'h0000};
  host_register_map_16bit #(.IDENTITY_VALUE(ID)) DUT (.clock, .reset,
    .host_select, .host_write, .host_read, .host_address, .host_write_data,
    .host_read_data, .host_read_valid, .irq_request, .source_address,
    .destination_address, .general_parameter_word, .connection_command_word,
    .connection_launch, .config_command_first, .config_command_second,
    .config_launch_first, .config_launch_second, .message_value, .ready_flag,
    .connection_established, .no_free_connection, .stream_connected,
    .pll_locked, .error_events, .slot_value_update, .slot_value_in,
    .gpio_change);
  host_cpu_model host (.clock, .host_select, .host_write, .host_read,
    .host_address, .host_write_data, .host_read_data, .host_read_valid);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    launches += connection_launch;
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    check($sformatf("register %h", a), d, exp);
  endtask
  task automatic pulse_done();
    @(negedge clock);
    connection_established = 1'b1;
    @(negedge clock);
    connection_established = 1'b0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    reset = 1'b1;
    {connection_established, no_free_connection, stream_connected} = 3'h0;
    {pll_locked, slot_value_update, gpio_change} = 3'h0;
    error_events = 16'h0000;
    slot_value_in = 16'h0000;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    for (int i = 0; i < 15; i++)
      rc(radr[i], rexp[i]);
    for (int i = 0; i < 12; i++)
    begin
      host.wr(wadr[i], 16'hffff);
      rc(wadr[i], wexp[i]);
    end
    check("general word", general_parameter_word, 16'hffff);
    check("second command", {8'h00, config_command_second}, 16'h00ff);
    check("message", {8'h00, message_value}, 16'h00ff);
    host.wr(OFF_CONNECTION_COMMAND, 16'hffff);
    rc(OFF_CONNECTION_COMMAND, 16'h0000);
    check("launches", 16'(launches), 16'h0000);
    pulse_done();
    rc(OFF_MAIN_IRQ_STATUS, 16'h0004);
    host.conn_cmd(16'h12b4, 16'h5678, 16'hffff);
    rc(OFF_SOURCE_ADDRESS, 16'h1294);
    rc(OFF_DESTINATION_ADDRESS, 16'h5618);
    check("destination port", destination_address, 16'h5618);
    rc(OFF_CONNECTION_COMMAND, 16'h3fff);
    check("launches", 16'(launches), 16'h0001);
    rc(OFF_MAIN_IRQ_STATUS, 16'h0000);
    pulse_done();
    host.wr(OFF_ERROR_IRQ_MASK, 16'h0000);
    @(negedge clock);
    error_events = 16'hffff;
    @(negedge clock);
    error_events = 16'h0000;
    rc(OFF_MAIN_IRQ_STATUS, 16'h0005);
    rc(OFF_ERROR_IRQ_STATUS, 16'hff3f);
    rc(OFF_ERROR_IRQ_STATUS, 16'h0000);
    rc(OFF_MAIN_IRQ_STATUS, 16'h0004);
    {no_free_connection, stream_connected, pll_locked} = 3'h7;
    rc(OFF_MAIN_IRQ_STATUS, 16'h00cc);
    host.wr(OFF_MAIN_IRQ_MASK, 16'h0000);
    repeat (2) @(negedge clock);
    check("irq", {15'h0, irq_request}, 16'h0000);
    slot_value_in = 16'ha55a;
    slot_value_update = 1'b1;
    @(negedge clock);
    slot_value_update = 1'b0;
    repeat (2) @(negedge clock);
    check("irq", {15'h0, irq_request}, 16'h0001);
    rc(OFF_SLOT_VALUE_READBACK, 16'ha55a);
    repeat (2) @(negedge clock);
    check("irq", {15'h0, irq_request}, 16'h0000);
    gpio_change = 1'b1;
    rc(OFF_MAIN_IRQ_STATUS, 16'h00ec);
    check("irq", {15'h0, irq_request}, 16'h0001);
    print_verdict();
  end
endmodule
`default_nettype wire
